//--- logic/timer_b_regs.sv
// timer type B counter, capture and register file
`timescale 1ns/1ns
// Overview of operation
// - overflow enable bit gates overflow interrupt
// - capture enable bit gates capture interrupt
// - overflow flag set on wrap max to zero
// - writing one clears overflow flag
// - capture flag cleared by one, or by capture value read in capture modes
// - timer modes flag when count equals top
// - frequency mode: capture, flag, restart count
// - event capture mode: capture and flag only
// - pulse mode: restart, opposite edge captures
// - combined mode flags and stops, second edge
// - pwm8 flags when count equals duty byte
// - pwm8 low byte period, high byte duty
// - run bit reflects counter running, read only
// - debug break halts unless run-in-break bit set
// - shared staging byte for 16-bit access
// - count readable writable as two bytes
// - bus write beats internal count update
// - compare value is top in timer modes
// - capture value held until next capture
// - counter mode encoding zero to seven
module timer_b_regs (
  input wire logic clk_sys,
  input wire logic rst,
  input wire timer_b_pkg::bus_req_s busReq,
  output logic [7:0] busRdData,
  input wire logic timerEnable,
  input wire timer_b_pkg::mode_e counterModeSelect,
  input wire logic captureEventEnable,
  input wire logic eventEdge,
  input wire logic eventIn,
  input wire logic debugBreak,
  output logic irqReq,
  output logic pwmOut
);
  timer_b_pkg::timer_state_s s;
  timer_b_pkg::timer_state_s n;
  logic halt;
  logic posEdge;
  logic negEdge;
  logic evOk;
  logic selEdge;
  logic oppEdge;
  logic tick;
  logic setOvf;
  logic setCapt;
  logic clrOvf;
  logic clrCapt;
  logic atTop;

  function automatic logic [15:0] inc16(input logic [15:0] c);
    return c + timer_b_pkg::COUNT_ONE;
  endfunction

  function automatic logic isCaptureMode(input timer_b_pkg::mode_e m);
    return (m == timer_b_pkg::MODE_CAPTURE) || (m == timer_b_pkg::MODE_FREQ) ||
      (m == timer_b_pkg::MODE_PULSE) || (m == timer_b_pkg::MODE_FREQ_PULSE);
  endfunction

  always_comb begin
    n = s;
    halt = debugBreak & ~s.runInBreak;
    posEdge = eventIn & ~s.evPrev;
    negEdge = ~eventIn & s.evPrev;
    evOk = captureEventEnable & timerEnable & ~halt;
    selEdge = evOk & (eventEdge ? negEdge : posEdge);
    oppEdge = evOk & (eventEdge ? posEdge : negEdge);
    tick = s.running & ~halt;
    atTop = s.cnt == s.compare_capture_value;
    setCapt = 1'b0;
    n.evPrev = eventIn;
    n.pwm = 1'b0;
    if (!timerEnable) begin
      n.running = 1'b0;
      n.phase = timer_b_pkg::PH_WAIT_FIRST;
    end else begin
      case (counterModeSelect)
        timer_b_pkg::MODE_PERIODIC: begin
          n.running = 1'b1;
          if (tick) begin
            if (atTop) begin
              n.cnt = timer_b_pkg::COUNT_ZERO;
              setCapt = 1'b1;
            end else begin
              n.cnt = inc16(s.cnt);
            end
          end
        end
        timer_b_pkg::MODE_TIMEOUT: begin
          if (selEdge) begin
            n.running = 1'b1;
          end
          if (oppEdge) begin
            n.running = 1'b0;
          end
          if (tick) begin
            if (atTop) begin
              n.cnt = timer_b_pkg::COUNT_ZERO;
              setCapt = 1'b1;
            end else begin
              n.cnt = inc16(s.cnt);
            end
          end
        end
        timer_b_pkg::MODE_SINGLE: begin
          if (selEdge || (eventEdge && oppEdge)) begin
            n.running = 1'b1;
          end
          if (tick) begin
            if (atTop) begin
              n.cnt = timer_b_pkg::COUNT_ZERO;
              n.running = 1'b0;
              setCapt = 1'b1;
            end else begin
              n.cnt = inc16(s.cnt);
            end
          end
        end
        timer_b_pkg::MODE_CAPTURE: begin
          n.running = 1'b1;
          if (tick) begin
            n.cnt = inc16(s.cnt);
          end
          if (selEdge) begin
            n.compare_capture_value = s.cnt;
            setCapt = 1'b1;
          end
        end
        timer_b_pkg::MODE_FREQ: begin
          n.running = 1'b1;
          if (selEdge) begin
            n.compare_capture_value = s.cnt;
            n.cnt = timer_b_pkg::COUNT_ZERO;
            setCapt = 1'b1;
          end else if (tick) begin
            n.cnt = inc16(s.cnt);
          end
        end
        timer_b_pkg::MODE_PULSE: begin
          n.running = 1'b1;
          if (selEdge) begin
            n.cnt = timer_b_pkg::COUNT_ZERO;
          end else if (tick) begin
            n.cnt = inc16(s.cnt);
          end
          if (oppEdge) begin
            n.compare_capture_value = s.cnt;
            setCapt = 1'b1;
          end
        end
        timer_b_pkg::MODE_FREQ_PULSE: begin
          if (tick) begin
            n.cnt = inc16(s.cnt);
          end
          case (s.phase)
            timer_b_pkg::PH_WAIT_FIRST: begin
              n.running = 1'b0;
              if (selEdge) begin
                n.cnt = timer_b_pkg::COUNT_ZERO;
                n.running = 1'b1;
                n.phase = timer_b_pkg::PH_WAIT_OPP;
              end
            end
            timer_b_pkg::PH_WAIT_OPP: begin
              if (oppEdge) begin
                n.compare_capture_value = s.cnt;
                n.phase = timer_b_pkg::PH_WAIT_SECOND;
              end
            end
            timer_b_pkg::PH_WAIT_SECOND: begin
              if (selEdge) begin
                n.running = 1'b0;
                n.cnt = s.cnt;
                setCapt = 1'b1;
                n.phase = timer_b_pkg::PH_DONE;
              end
            end
            timer_b_pkg::PH_DONE: begin
              n.running = 1'b0;
              // rearm once software has taken the result
              if (!s.capture_irq) begin
                n.phase = timer_b_pkg::PH_WAIT_FIRST;
              end
            end
            default: begin
              n.phase = timer_b_pkg::PH_WAIT_FIRST;
            end
          endcase
        end
        timer_b_pkg::MODE_PWM8: begin
          n.running = 1'b1;
          if (tick) begin
            if (s.cnt[7:0] == s.compare_capture_value[7:0]) begin
              n.cnt = timer_b_pkg::COUNT_ZERO;
            end else begin
              n.cnt = inc16(s.cnt);
            end
            if (s.cnt[7:0] == s.compare_capture_value[15:8]) begin
              setCapt = 1'b1;
            end
          end
          n.pwm = s.cnt[7:0] < s.compare_capture_value[15:8];
        end
        default: begin
          n.running = 1'b0;
        end
      endcase
    end
    setOvf = tick && (s.cnt == timer_b_pkg::COUNT_MAX) &&
      (n.cnt == timer_b_pkg::COUNT_ZERO);

    // register bus
    clrOvf = 1'b0;
    clrCapt = 1'b0;
    if (busReq.write) begin
      case (busReq.addr)
        timer_b_pkg::ADDR_IRQ_ENABLE: begin
          n.ien = busReq.wrData[1:0];
        end
        timer_b_pkg::ADDR_IRQ_FLAGS: begin
          clrOvf = busReq.wrData[timer_b_pkg::BIT_OVF];
          clrCapt = busReq.wrData[timer_b_pkg::BIT_CAPTURE_IRQ];
        end
        timer_b_pkg::ADDR_DEBUG_HALT: begin
          n.runInBreak = busReq.wrData[timer_b_pkg::BIT_RUN_IN_BREAK];
        end
        timer_b_pkg::ADDR_STAGING, timer_b_pkg::ADDR_COUNT_LO,
        timer_b_pkg::ADDR_COMPARE_CAPTURE_VALUE_LO: begin
          n.temp = busReq.wrData;
        end
        timer_b_pkg::ADDR_COUNT_HI: begin
          n.cnt = {busReq.wrData, s.temp};
        end
        timer_b_pkg::ADDR_COMPARE_CAPTURE_VALUE_HI: begin
          n.compare_capture_value = {busReq.wrData, s.temp};
        end
        default: begin
          n.temp = s.temp;
        end
      endcase
    end
    if (busReq.read) begin
      case (busReq.addr)
        timer_b_pkg::ADDR_IRQ_ENABLE: begin
          n.rdData = {6'h00, s.ien};
        end
        timer_b_pkg::ADDR_IRQ_FLAGS: begin
          n.rdData = {6'h00, s.ovf, s.capture_irq};
        end
        timer_b_pkg::ADDR_RUN_STATE: begin
          n.rdData = {7'h00, s.running};
        end
        timer_b_pkg::ADDR_DEBUG_HALT: begin
          n.rdData = {7'h00, s.runInBreak};
        end
        timer_b_pkg::ADDR_STAGING, timer_b_pkg::ADDR_COUNT_HI,
        timer_b_pkg::ADDR_COMPARE_CAPTURE_VALUE_HI: begin
          n.rdData = s.temp;
        end
        timer_b_pkg::ADDR_COUNT_LO: begin
          n.rdData = s.cnt[7:0];
          n.temp = s.cnt[15:8];
        end
        timer_b_pkg::ADDR_COMPARE_CAPTURE_VALUE_LO: begin
          n.rdData = s.compare_capture_value[7:0];
          n.temp = s.compare_capture_value[15:8];
          clrCapt = clrCapt | isCaptureMode(counterModeSelect);
        end
        default: begin
          n.rdData = timer_b_pkg::BYTE_ZERO;
        end
      endcase
    end
    // a new event wins over a clear in the same cycle
    n.ovf = (s.ovf & ~clrOvf) | setOvf;
    n.capture_irq = (s.capture_irq & ~clrCapt) | setCapt;
    n.irq = (s.ovf & s.ien[timer_b_pkg::BIT_OVF]) |
      (s.capture_irq & s.ien[timer_b_pkg::BIT_CAPTURE_IRQ]);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s <= timer_b_pkg::STATE_RESET;
    end else begin
      s <= n;
    end
  end

  assign busRdData = s.rdData;
  assign irqReq = s.irq;
  assign pwmOut = s.pwm;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_irq_follows_flags;
    1'b1 |=> irqReq == ($past(s.ovf & s.ien[1]) | $past(s.capture_irq & s.ien[0]));
  endproperty
  a_irq_follows_flags: assert property (p_irq_follows_flags)
    else $error("interrupt output does not follow enabled flags");

  property p_ovf_cause;
    $rose(s.ovf) |-> $past(s.cnt) == timer_b_pkg::COUNT_MAX;
  endproperty
  a_ovf_cause: assert property (p_ovf_cause)
    else $error("overflow flag set without a wrap");

  property p_ovf_clear;
    busReq.write && busReq.addr == timer_b_pkg::ADDR_IRQ_FLAGS &&
      busReq.wrData[1] && !setOvf |=> !s.ovf;
  endproperty
  a_ovf_clear: assert property (p_ovf_clear)
    else $error("overflow flag not cleared by write of one");

  property p_periodic_top;
    timerEnable && counterModeSelect == timer_b_pkg::MODE_PERIODIC && tick &&
      atTop && !busReq.write |=> s.capture_irq && s.cnt == timer_b_pkg::COUNT_ZERO;
  endproperty
  a_periodic_top: assert property (p_periodic_top)
    else $error("periodic mode missed top match");

  property p_freq_capture;
    timerEnable && counterModeSelect == timer_b_pkg::MODE_FREQ && selEdge &&
      !busReq.write |=> s.capture_irq && s.compare_capture_value == $past(s.cnt) && s.cnt == timer_b_pkg::COUNT_ZERO;
  endproperty
  a_freq_capture: assert property (p_freq_capture)
    else $error("frequency capture wrong");

  property p_event_capture;
    timerEnable && counterModeSelect == timer_b_pkg::MODE_CAPTURE && selEdge &&
      !busReq.write |=> s.capture_irq && s.compare_capture_value == $past(s.cnt);
  endproperty
  a_event_capture: assert property (p_event_capture)
    else $error("event capture wrong");

  property p_run_read;
    busReq.read && busReq.addr == timer_b_pkg::ADDR_RUN_STATE |=>
      busRdData == {7'h00, $past(s.running)};
  endproperty
  a_run_read: assert property (p_run_read)
    else $error("run state read wrong");

  property p_break_halts;
    halt && !(busReq.write && busReq.addr == timer_b_pkg::ADDR_COUNT_HI) |=> $stable(s.cnt);
  endproperty
  a_break_halts: assert property (p_break_halts)
    else $error("counter moved during debug break");

  property p_bus_wins;
    busReq.write && busReq.addr == timer_b_pkg::ADDR_COUNT_HI |=>
      s.cnt == {$past(busReq.wrData), $past(s.temp)};
  endproperty
  a_bus_wins: assert property (p_bus_wins)
    else $error("count write lost to internal update");
endmodule // timer_b_regs

//--- logic/timer_b_pkg.sv
// constants and types for the timer type B register block
package timer_b_pkg;
  localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h5;
  localparam logic [3:0] ADDR_IRQ_FLAGS = 4'h6;
  localparam logic [3:0] ADDR_RUN_STATE = 4'h7;
  localparam logic [3:0] ADDR_DEBUG_HALT = 4'h8;
  localparam logic [3:0] ADDR_STAGING = 4'h9;
  localparam logic [3:0] ADDR_COUNT_LO = 4'ha;
  localparam logic [3:0] ADDR_COUNT_HI = 4'hb;
  localparam logic [3:0] ADDR_COMPARE_CAPTURE_VALUE_LO = 4'hc;
  localparam logic [3:0] ADDR_COMPARE_CAPTURE_VALUE_HI = 4'hd;
  localparam int BIT_OVF = 1;
  localparam int BIT_CAPTURE_IRQ = 0;
  localparam int BIT_RUN = 0;
  localparam int BIT_RUN_IN_BREAK = 0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  typedef enum logic [2:0] {
    MODE_PERIODIC = 3'h0,
    MODE_TIMEOUT = 3'h1,
    MODE_CAPTURE = 3'h2,
    MODE_FREQ = 3'h3,
    MODE_PULSE = 3'h4,
    MODE_FREQ_PULSE = 3'h5,
    MODE_SINGLE = 3'h6,
    MODE_PWM8 = 3'h7
  } mode_e;
  typedef enum logic [1:0] {
    PH_WAIT_FIRST,
    PH_WAIT_OPP,
    PH_WAIT_SECOND,
    PH_DONE
  } fpw_phase_e;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wrData;
    logic write;
    logic read;
  } bus_req_s;
  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] compare_capture_value;
    logic [7:0] temp;
    logic [1:0] ien;
    logic ovf;
    logic capture_irq;
    logic runInBreak;
    logic running;
    logic evPrev;
    fpw_phase_e phase;
    logic [7:0] rdData;
    logic irq;
    logic pwm;
  } timer_state_s;
  localparam timer_state_s STATE_RESET = '0;
endpackage

//--- sim/tb_timer_b_regs.sv
// self-checking bench for the timer type B register block
`timescale 1ns/1ns
module tb_timer_b_regs;
  logic clk_sys;
  logic rst;
  timer_b_pkg::bus_req_s busReq;
  logic [7:0] busRdData;
  logic timerEnable;
  timer_b_pkg::mode_e counterModeSelect;
  logic captureEventEnable;
  logic eventEdge;
  logic eventIn;
  logic debugBreak;
  logic irqReq;
  logic pwmOut;
  int miscompares;
  int cmp_count;
  int hiCnt;
  logic [7:0] b;
  logic [15:0] w;
  logic [15:0] c1;
  timer_b_pkg::mode_e topModes [3];

  timer_b_regs i_timer_b_regs (.clk_sys(clk_sys), .rst(rst), .busReq(busReq),
    .busRdData(busRdData), .timerEnable(timerEnable), .counterModeSelect(counterModeSelect),
    .captureEventEnable(captureEventEnable), .eventEdge(eventEdge), .eventIn(eventIn),
    .debugBreak(debugBreak), .irqReq(irqReq), .pwmOut(pwmOut));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    busReq.addr = a;
    busReq.wrData = d;
    busReq.write = 1'b1;
    @(negedge clk_sys);
    busReq.write = 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    busReq.addr = a;
    busReq.read = 1'b1;
    @(negedge clk_sys);
    busReq.read = 1'b0;
    d = busRdData;
  endtask

  // low byte first so the staging byte pairs the halves
  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 4'h1, v[15:8]);
  endtask

  task automatic rd16(input logic [3:0] a, output logic [15:0] v);
    rd(a, v[7:0]);
    rd(a + 4'h1, v[15:8]);
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chkok(input string name, input logic ok, input logic [15:0] got);
    cmp_count++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("BAD %s expected in range seen %h", name, got);
    end
  endtask

  // event pattern: high in [r1,f1) and from r2 on, counter left running
  task automatic ev_run(input timer_b_pkg::mode_e m, input int r1, input int f1,
                        input int r2, input int total);
    wr(timer_b_pkg::ADDR_IRQ_FLAGS, 8'h03);
    counterModeSelect = m;
    wr16(timer_b_pkg::ADDR_COUNT_LO, 16'h0000);
    timerEnable = 1'b1;
    for (int t = 0; t < total; t++) begin
      eventIn = (t >= r1 && t < f1) || (t >= r2);
      @(negedge clk_sys);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #400000;
    miscompares++;
    test_done();
  end

  initial begin
    busReq = '0;
    timerEnable = 1'b0;
    counterModeSelect = timer_b_pkg::MODE_PERIODIC;
    captureEventEnable = 1'b1;
    eventEdge = 1'b0;
    eventIn = 1'b0;
    debugBreak = 1'b0;
    miscompares = 0;
    cmp_count = 0;
    topModes = '{timer_b_pkg::MODE_PERIODIC, timer_b_pkg::MODE_TIMEOUT, timer_b_pkg::MODE_SINGLE};
    rst = 1'b1;
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    for (int a = 5; a < 14; a++) begin
      rd(4'(a), b);
      chk("reset value", 16'h0000, b);
    end
    rd(4'hf, b);
    chk("unmapped", 16'h0000, b);
    wr(timer_b_pkg::ADDR_IRQ_ENABLE, 8'h03);
    rd(timer_b_pkg::ADDR_IRQ_ENABLE, b);
    chk("irq_enable", 16'h0003, b);
    wr(timer_b_pkg::ADDR_DEBUG_HALT, 8'h01);
    rd(timer_b_pkg::ADDR_DEBUG_HALT, b);
    chk("debug_halt_control", 16'h0001, b);
    wr(timer_b_pkg::ADDR_DEBUG_HALT, 8'h00);
    wr(timer_b_pkg::ADDR_STAGING, 8'ha5);
    rd(timer_b_pkg::ADDR_STAGING, b);
    chk("byte_staging", 16'h00a5, b);
    wr(timer_b_pkg::ADDR_RUN_STATE, 8'h01);
    rd(timer_b_pkg::ADDR_RUN_STATE, b);
    chk("run_state write", 16'h0000, b);
    wr16(timer_b_pkg::ADDR_COUNT_LO, 16'h1234);
    rd16(timer_b_pkg::ADDR_COUNT_LO, w);
    chk("count_value", 16'h1234, w);
    $display("test registers done");
    wr(timer_b_pkg::ADDR_IRQ_ENABLE, 8'h02);
    wr16(timer_b_pkg::ADDR_COMPARE_CAPTURE_VALUE_LO, 16'h0100);
    wr16(timer_b_pkg::ADDR_COUNT_LO, 16'hfff0);
    timerEnable = 1'b1;
    rd(timer_b_pkg::ADDR_RUN_STATE, b);
    chk("run_state running", 16'h0001, b);
    tick(30);
    timerEnable = 1'b0;
    tick(2);
    rd(timer_b_pkg::ADDR_IRQ_FLAGS, b);
    chk("overflow flag", 16'h0002, b);
    chk("irq overflow", 16'h0001, irqReq);
    wr(timer_b_pkg::ADDR_IRQ_ENABLE, 8'h01);
    tick(2);
    chk("irq masked", 16'h0000, irqReq);
    wr(timer_b_pkg::ADDR_IRQ_FLAGS, 8'h00);
    rd(timer_b_pkg::ADDR_IRQ_FLAGS, b);
    chk("flag write zero", 16'h0002, b);
    wr(timer_b_pkg::ADDR_IRQ_FLAGS, 8'h02);
    rd(timer_b_pkg::ADDR_IRQ_FLAGS, b);
    chk("flag write one", 16'h0000, b);
    $display("test overflow done");
    wr16(timer_b_pkg::ADDR_COMPARE_CAPTURE_VALUE_LO, 16'h0006);
    foreach (topModes[i]) begin
      ev_run(topModes[i], 2, 999, 999, 20);
      timerEnable = 1'b0;
      eventIn = 1'b0;
      tick(2);
      rd(timer_b_pkg::ADDR_IRQ_FLAGS, b);
      chk("top match flag", 16'h0001, b);
      chk("irq capture", 16'h0001, irqReq);
      rd16(timer_b_pkg::ADDR_COUNT_LO, w);
      chkok("count below top", w <= 16'h0006, w);
      wr(timer_b_pkg::ADDR_IRQ_FLAGS, 8'h01);
      rd(timer_b_pkg::ADDR_IRQ_FLAGS, b);
      chk("capture flag clear", 16'h0000, b);
    end
    $display("test top modes done");
    wr16(timer_b_pkg::ADDR_COMPARE_CAPTURE_VALUE_LO, 16'h8000);
    ev_run(timer_b_pkg::MODE_PERIODIC, 999, 999, 999, 2);
    debugBreak = 1'b1;
    rd16(timer_b_pkg::ADDR_COUNT_LO, w);
    tick(10);
    rd16(timer_b_pkg::ADDR_COUNT_LO, c1);
    chk("halted count", w, c1);
    wr(timer_b_pkg::ADDR_DEBUG_HALT, 8'h01);
    rd16(timer_b_pkg::ADDR_COUNT_LO, w);
    tick(10);
    rd16(timer_b_pkg::ADDR_COUNT_LO, c1);
    chkok("run in break", c1 > w, c1);
    debugBreak = 1'b0;
    wr16(timer_b_pkg::ADDR_COUNT_LO, 16'h0000);
    timerEnable = 1'b0;
    rd16(timer_b_pkg::ADDR_COUNT_LO, w);
    chkok("write beats count", w <= 16'h0002, w);
    $display("test debug done");
    ev_run(timer_b_pkg::MODE_CAPTURE, 10, 20, 999, 30);
    timerEnable = 1'b0;
    rd(timer_b_pkg::ADDR_IRQ_FLAGS, b);
    chk("capture flag", 16'h0001, b);
    rd16(timer_b_pkg::ADDR_COMPARE_CAPTURE_VALUE_LO, c1);
    chkok("captured count", c1 >= 16'h0008 && c1 <= 16'h000e, c1);
    rd(timer_b_pkg::ADDR_IRQ_FLAGS, b);
    chk("read clears flag", 16'h0000, b);
    rd16(timer_b_pkg::ADDR_COUNT_LO, w);
    chkok("no restart", w >= c1 + 16'h0012, w);
    rd16(timer_b_pkg::ADDR_COMPARE_CAPTURE_VALUE_LO, w);
    chk("capture held", c1, w);
    ev_run(timer_b_pkg::MODE_FREQ, 10, 999, 999, 15);
    timerEnable = 1'b0;
    eventIn = 1'b0;
    rd(timer_b_pkg::ADDR_IRQ_FLAGS, b);
    chk("freq flag", 16'h0001, b);
    rd16(timer_b_pkg::ADDR_COMPARE_CAPTURE_VALUE_LO, c1);
    chkok("freq capture", c1 >= 16'h0008 && c1 <= 16'h000e, c1);
    rd16(timer_b_pkg::ADDR_COUNT_LO, w);
    chkok("freq restart", w <= 16'h0007, w);
    ev_run(timer_b_pkg::MODE_PULSE, 4, 14, 999, 20);
    timerEnable = 1'b0;
    rd(timer_b_pkg::ADDR_IRQ_FLAGS, b);
    chk("pulse flag", 16'h0001, b);
    rd16(timer_b_pkg::ADDR_COMPARE_CAPTURE_VALUE_LO, c1);
    chkok("pulse width", c1 >= 16'h0009 && c1 <= 16'h000b, c1);
    rd16(timer_b_pkg::ADDR_COUNT_LO, w);
    chkok("pulse continues", w >= c1 + 16'h0004, w);
    ev_run(timer_b_pkg::MODE_FREQ_PULSE, 4, 10, 16, 30);
    rd(timer_b_pkg::ADDR_IRQ_FLAGS, b);
    chk("second edge flag", 16'h0001, b);
    rd(timer_b_pkg::ADDR_RUN_STATE, b);
    chk("stopped run_state", 16'h0000, b);
    rd16(timer_b_pkg::ADDR_COUNT_LO, w);
    tick(5);
    rd16(timer_b_pkg::ADDR_COUNT_LO, c1);
    chk("stopped count", w, c1);
    timerEnable = 1'b0;
    eventIn = 1'b0;
    // falling edge selected: rise at 2 ignored, fall at 12 captures
    eventEdge = 1'b1;
    ev_run(timer_b_pkg::MODE_CAPTURE, 2, 12, 999, 20);
    timerEnable = 1'b0;
    eventEdge = 1'b0;
    rd(timer_b_pkg::ADDR_IRQ_FLAGS, b);
    chk("falling edge flag", 16'h0001, b);
    rd16(timer_b_pkg::ADDR_COMPARE_CAPTURE_VALUE_LO, c1);
    chkok("falling edge capture", c1 >= 16'h000a && c1 <= 16'h000c, c1);
    $display("test capture modes done");
    wr16(timer_b_pkg::ADDR_COMPARE_CAPTURE_VALUE_LO, 16'h040f);
    ev_run(timer_b_pkg::MODE_PWM8, 999, 999, 999, 1);
    hiCnt = 0;
    repeat (160) begin
      @(negedge clk_sys);
      hiCnt += (pwmOut === 1'b1);
    end
    chkok("pwm duty", hiCnt >= 36 && hiCnt <= 46, 16'(hiCnt));
    timerEnable = 1'b0;
    rd(timer_b_pkg::ADDR_IRQ_FLAGS, b);
    chk("pwm flag", 16'h0001, b);
    rd16(timer_b_pkg::ADDR_COUNT_LO, w);
    chk("pwm count high", 16'h0000, w[15:8]);
    $display("test pwm done");
    test_done();
  end
endmodule // tb_timer_b_regs
